/* hdl/boot_select_pkg.sv */
// constants for the power-on node identifier and bit rate selector
// assumes a 16-bit setup store answering reads one word at a time
// Summary of operation
// - table identifier may be 1 to 255
// - canopen: identifier above 127 at power-on becomes 255, unconfigured
// - unconfigured: accept only layer setting commands
// - unconfigured: send nothing but layer setting answers
// - serial write of 1..127 leaves unconfigured state
// - valid table, flag set: identifier from table
// - valid table, flag clear: last stored identifier, else hardware inputs
// - invalid table: stored identifier, else hardware inputs
// - only four bit rates exist
// - valid table, rate flag set: rate from table
// - otherwise use last stored bit rate
// - nothing stored and invalid table or rate flag clear: 500 kbit/s
// - copy table to ram at power-on, use copy
package boot_select_pkg;

	// ==========================================================
	// setup table layout
	localparam int          TBL_WORDS     = 4;
	localparam logic [15:0] TBL_NVM_BASE  = 16'h0000;
	localparam logic [1:0]  W_SIGNATURE   = 2'h0;
	localparam logic [1:0]  W_FLAGS       = 2'h1;
	localparam logic [1:0]  W_NODE_ID     = 2'h2;
	localparam logic [1:0]  W_RATE        = 2'h3;
	// arbitrary marker of a valid table
	localparam logic [15:0] TBL_SIGNATURE = 16'ha55a;
	localparam int          FLAG_ID_POS   = 0;
	localparam int          FLAG_RATE_POS = 1;

	// ==========================================================
	// identifiers
	localparam logic [7:0] ID_HW_CODE   = 8'h00;
	localparam logic [7:0] ID_MIN       = 8'h01;
	localparam logic [7:0] ID_CANOPEN_MAX = 8'h7f;
	localparam logic [7:0] ID_UNCONF    = 8'hff;

	// ==========================================================
	// bit rates
	typedef enum logic [1:0] {
		RATE_125K = 2'h0,
		RATE_250K = 2'h1,
		RATE_500K = 2'h2,
		RATE_1M   = 2'h3
	} rate_e;
	localparam logic [2:0] RATE_CODE_FW_DEFAULT = 3'h4;
	localparam rate_e      RATE_FW_DEFAULT      = RATE_500K;

	// ==========================================================
	// register map, byte addresses
	localparam logic [5:0] REG_STATUS    = 6'h00;
	localparam logic [5:0] REG_SERIAL_ID = 6'h04;
	localparam logic [5:0] REG_TBL_BASE  = 6'h10;
	localparam logic [1:0] RESP_OKAY     = 2'h0;
	localparam logic [1:0] RESP_SLVERR   = 2'h2;

	typedef enum logic [2:0] {
		ST_LOAD   = 3'b001,
		ST_SELECT = 3'b010,
		ST_RUN    = 3'b100
	} state_e;

endpackage : boot_select_pkg

/* hdl/node_id_bitrate_boot_select.sv */
// power-on choice of node identifier and bit rate, with traffic gating
// assumes a setup store answering each read with nvm_rvalid
`timescale 1ns/100ps
module node_id_bitrate_boot_select
	import boot_select_pkg::*;
(
	// clock and reset
	input  wire logic        core_clk,
	input  wire logic        rst_n,
	// setup store
	output logic             nvm_rd,
	output logic [15:0]      nvm_addr,
	input  wire logic [15:0] nvm_rdata,
	input  wire logic        nvm_rvalid,
	// straps and previously stored values
	input  wire logic        canopen_mode,
	input  wire logic [7:0]  hardware_node_select_inputs,
	input  wire logic        stored_id_valid,
	input  wire logic [7:0]  stored_id,
	input  wire logic        stored_rate_valid,
	input  wire logic [1:0]  stored_rate,
	// layer setting requests from the network master
	input  wire logic        lss_id_we,
	input  wire logic [7:0]  lss_id,
	input  wire logic        lss_rate_we,
	input  wire logic [1:0]  lss_rate,
	// persist last values
	output logic             persist_we,
	output logic [7:0]       node_id,
	output logic [1:0]       bit_rate,
	// network traffic gating
	input  wire logic        rx_valid,
	input  wire logic        rx_is_lss,
	output logic             rx_accept,
	input  wire logic        tx_req,
	input  wire logic        tx_is_lss,
	output logic             tx_grant,
	output logic             tx_enable,
	output logic             unconfigured,
	output logic             select_done,
	// axi4-lite slave
	input  wire logic [5:0]  s_awaddr,
	input  wire logic        s_awvalid,
	output logic             s_awready,
	input  wire logic [31:0] s_wdata,
	input  wire logic [3:0]  s_wstrb,
	input  wire logic        s_wvalid,
	output logic             s_wready,
	output logic [1:0]       s_bresp,
	output logic             s_bvalid,
	input  wire logic        s_bready,
	input  wire logic [5:0]  s_araddr,
	input  wire logic        s_arvalid,
	output logic             s_arready,
	output logic [31:0]      s_rdata,
	output logic [1:0]       s_rresp,
	output logic             s_rvalid,
	input  wire logic        s_rready
);

	// ==========================================================
	// state
	typedef struct packed {
		state_e                     st;
		logic                       rd;
		logic                       wait_rd;
		logic [1:0]                 idx;
		logic [15:0]                addr;
		logic [TBL_WORDS-1:0][15:0] tbl;
		logic [7:0]                 id;
		logic [1:0]                 rate;
		logic                       unconf;
		logic                       done;
		logic                       tx_en;
		logic                       rx_acc;
		logic                       tx_gnt;
		logic                       persist;
		logic                       awrdy;
		logic                       wrdy;
		logic                       aw_got;
		logic [5:0]                 aw_addr;
		logic                       w_got;
		logic [31:0]                w_data;
		logic [3:0]                 w_strb;
		logic                       bvalid;
		logic [1:0]                 bresp;
		logic                       arrdy;
		logic                       rvalid;
		logic [31:0]                rdata;
		logic [1:0]                 rresp;
	} state_s;

	state_s r;
	state_s next_r;

	logic       tbl_ok;
	logic [7:0] src_id;
	logic [7:0] raw_id;
	logic [2:0] tbl_rate;
	logic [5:0] ra;

	// ==========================================================
	// next state
	always_comb begin
		next_r = r;
		next_r.rd = 1'b0;
		next_r.persist = 1'b0;
		tbl_ok = (r.tbl[W_SIGNATURE] == TBL_SIGNATURE);
		// any code past the four rates means the default
		tbl_rate = (r.tbl[W_RATE][15:3] == 13'h0000)
			? r.tbl[W_RATE][2:0] : RATE_CODE_FW_DEFAULT;
		// selection reads only the ram copy, never the store
		if (tbl_ok && r.tbl[W_FLAGS][FLAG_ID_POS]) begin
			src_id = r.tbl[W_NODE_ID][7:0];
		end else if (stored_id_valid) begin
			src_id = stored_id;
		end else begin
			src_id = ID_HW_CODE;
		end
		raw_id = (src_id == ID_HW_CODE) ? hardware_node_select_inputs
			: src_id;
		ra = s_araddr;

		case (r.st)
			ST_LOAD: begin
				// copy the whole table before selection runs
				if (!r.wait_rd) begin
					next_r.rd = 1'b1;
					next_r.wait_rd = 1'b1;
					next_r.addr = TBL_NVM_BASE + {14'h0000, r.idx};
				end else if (nvm_rvalid) begin
					next_r.tbl[r.idx] = nvm_rdata;
					next_r.wait_rd = 1'b0;
					next_r.idx = r.idx + 2'h1;
					if (r.idx == 2'(TBL_WORDS - 1)) begin
						next_r.st = ST_SELECT;
					end
				end
			end
			ST_SELECT: begin
				if (canopen_mode && raw_id > ID_CANOPEN_MAX) begin
					next_r.id = ID_UNCONF;
					next_r.unconf = 1'b1;
				end else begin
					next_r.id = raw_id;
					next_r.unconf = 1'b0;
				end
				if (tbl_ok && r.tbl[W_FLAGS][FLAG_RATE_POS]) begin
					// codes past the default fall back to 500k
					next_r.rate = (tbl_rate < RATE_CODE_FW_DEFAULT)
						? tbl_rate[1:0] : RATE_FW_DEFAULT;
				end else if (stored_rate_valid) begin
					next_r.rate = stored_rate;
				end else begin
					next_r.rate = RATE_FW_DEFAULT;
				end
				next_r.persist = tbl_ok;
				next_r.done = 1'b1;
				next_r.st = ST_RUN;
			end
			ST_RUN: begin
				next_r.tx_en = 1'b1;
				if (lss_id_we) begin
					next_r.id = lss_id;
					next_r.unconf = (lss_id < ID_MIN)
						|| (lss_id > ID_CANOPEN_MAX);
					next_r.persist = 1'b1;
				end
				if (lss_rate_we) begin
					next_r.rate = lss_rate;
					next_r.persist = 1'b1;
				end
			end
			default: begin
				next_r.st = ST_LOAD;
			end
		endcase

		// gating of traffic while unconfigured
		next_r.rx_acc = rx_valid && r.done
			&& (!r.unconf || rx_is_lss);
		next_r.tx_gnt = tx_req && r.tx_en
			&& (!r.unconf || tx_is_lss);

		// axi write: address and data taken in either order
		if (s_awvalid && r.awrdy) begin
			next_r.aw_got = 1'b1;
			next_r.aw_addr = s_awaddr;
		end
		if (s_wvalid && r.wrdy) begin
			next_r.w_got = 1'b1;
			next_r.w_data = s_wdata;
			next_r.w_strb = s_wstrb;
		end
		if (r.aw_got && r.w_got && !r.bvalid) begin
			next_r.aw_got = 1'b0;
			next_r.w_got = 1'b0;
			next_r.bvalid = 1'b1;
			next_r.bresp = RESP_SLVERR;
			if (r.aw_addr == REG_SERIAL_ID) begin
				next_r.bresp = RESP_OKAY;
				// serial rescue: only a valid canopen id clears it
				if (r.w_strb[0] && r.st == ST_RUN
					&& r.w_data[7:0] >= ID_MIN
					&& r.w_data[7:0] <= ID_CANOPEN_MAX) begin
					next_r.id = r.w_data[7:0];
					next_r.unconf = 1'b0;
					next_r.persist = 1'b1;
				end
			end else if (r.aw_addr == REG_STATUS
				|| r.aw_addr[5:4] == REG_TBL_BASE[5:4]) begin
				next_r.bresp = RESP_OKAY;
			end
		end
		if (r.bvalid && s_bready) begin
			next_r.bvalid = 1'b0;
		end
		next_r.awrdy = !next_r.aw_got && !next_r.bvalid;
		next_r.wrdy = !next_r.w_got && !next_r.bvalid;

		// axi read, answer one cycle after the address is taken
		if (s_arvalid && r.arrdy) begin
			next_r.arrdy = 1'b0;
			next_r.rvalid = 1'b1;
			next_r.rresp = RESP_OKAY;
			next_r.rdata = 32'h0000_0000;
			if (ra == REG_STATUS) begin
				next_r.rdata = {20'h0_0000, r.unconf, r.done,
					r.rate, r.id};
			end else if (ra == REG_SERIAL_ID) begin
				next_r.rdata = {24'h00_0000, r.id};
			end else if (ra[5:4] == REG_TBL_BASE[5:4]
				&& ra[1:0] == 2'h0) begin
				next_r.rdata = {16'h0000, r.tbl[ra[3:2]]};
			end else begin
				next_r.rresp = RESP_SLVERR;
			end
		end
		if (r.rvalid && s_rready) begin
			next_r.rvalid = 1'b0;
			next_r.arrdy = 1'b1;
		end
	end

	// ==========================================================
	// registers
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			r <= '0;
			r.st <= ST_LOAD;
			r.rate <= RATE_FW_DEFAULT;
			r.arrdy <= 1'b1;
			r.addr <= TBL_NVM_BASE;
		end else begin
			r <= next_r;
		end
	end

	// ==========================================================
	// outputs, all from flops
	assign nvm_rd       = r.rd;
	assign nvm_addr     = r.addr;
	assign persist_we   = r.persist;
	assign node_id      = r.id;
	assign bit_rate     = r.rate;
	assign rx_accept    = r.rx_acc;
	assign tx_grant     = r.tx_gnt;
	assign tx_enable    = r.tx_en;
	assign unconfigured = r.unconf;
	assign select_done  = r.done;
	assign s_awready    = r.awrdy;
	assign s_wready     = r.wrdy;
	assign s_bvalid     = r.bvalid;
	assign s_bresp      = r.bresp;
	assign s_arready    = r.arrdy;
	assign s_rvalid     = r.rvalid;
	assign s_rdata      = r.rdata;
	assign s_rresp      = r.rresp;

	// ==========================================================
	// assertions
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_n);

	AST_CANOPEN_CAP: assert property (
		$rose(r.done) && canopen_mode |-> r.id <= ID_CANOPEN_MAX
			|| (r.id == ID_UNCONF && r.unconf))
		else $error("canopen id above 127 not mapped to 255");
	AST_RX_GATE: assert property (
		rx_accept |-> $past(rx_is_lss) || !$past(r.unconf))
		else $error("non-lss frame accepted while unconfigured");
	AST_TX_GATE: assert property (
		tx_grant && $past(r.unconf) |-> $past(tx_is_lss))
		else $error("non-lss transmit while unconfigured");
	AST_SERIAL_EXIT: assert property (
		r.aw_got && r.w_got && !r.bvalid && r.st == ST_RUN
		&& r.aw_addr == REG_SERIAL_ID && r.w_strb[0]
		&& r.w_data[7:0] >= ID_MIN && r.w_data[7:0] <= ID_CANOPEN_MAX
		&& !lss_id_we
		|=> !r.unconf && r.id == $past(r.w_data[7:0]) && persist_we)
		else $error("serial id write did not configure");
	AST_TBL_ID: assert property (
		r.st == ST_SELECT && tbl_ok && r.tbl[W_FLAGS][FLAG_ID_POS]
		&& r.tbl[W_NODE_ID][7:0] != ID_HW_CODE
		&& (!canopen_mode || r.tbl[W_NODE_ID][7:0] <= ID_CANOPEN_MAX)
		|=> r.id == $past(r.tbl[W_NODE_ID][7:0]))
		else $error("table identifier not used");
	AST_STORED_ID: assert property (
		r.st == ST_SELECT && tbl_ok && !r.tbl[W_FLAGS][FLAG_ID_POS]
		&& stored_id_valid && stored_id != ID_HW_CODE
		&& (!canopen_mode || stored_id <= ID_CANOPEN_MAX)
		|=> r.id == $past(stored_id))
		else $error("stored identifier not used");
	AST_HW_ID: assert property (
		r.st == ST_SELECT && !tbl_ok && !stored_id_valid
		&& (!canopen_mode || hardware_node_select_inputs <= ID_CANOPEN_MAX)
		|=> r.id == $past(hardware_node_select_inputs))
		else $error("hardware identifier not used");
	AST_TBL_RATE: assert property (
		r.st == ST_SELECT && tbl_ok && r.tbl[W_FLAGS][FLAG_RATE_POS]
		|=> (r.tbl[W_RATE] < RATE_CODE_FW_DEFAULT)
		? r.rate == r.tbl[W_RATE][1:0] : r.rate == RATE_500K)
		else $error("table bit rate not used");
	AST_STORED_RATE: assert property (
		r.st == ST_SELECT && stored_rate_valid
		&& !(tbl_ok && r.tbl[W_FLAGS][FLAG_RATE_POS])
		|=> r.rate == $past(stored_rate))
		else $error("stored bit rate not used");
	AST_LSS_RATE: assert property (
		r.st == ST_RUN && lss_rate_we |=> r.rate == $past(lss_rate))
		else $error("layer setting rate not taken");
	AST_RATE_DEF: assert property (
		r.st == ST_SELECT && !tbl_ok && !stored_rate_valid
		|=> r.rate == RATE_500K ##1 r.tx_en)
		else $error("default rate not 500k");
	AST_NO_EARLY_TX: assert property (
		!r.done |-> !tx_enable && !tx_grant)
		else $error("transmit before selection finished");
	AST_LOAD_ORDER: assert property (
		nvm_rd |-> r.st == ST_LOAD ##1 !nvm_rd)
		else $error("store read outside load");
	AST_RD_ANSWER: assert property (
		s_arvalid && s_arready |=> s_rvalid && !s_arready)
		else $error("read not answered next cycle");

	COV_UNCONF: cover property ($rose(r.unconf));
	COV_SERIAL: cover property ($fell(r.unconf));
	COV_TBL_RATE: cover property (
		r.st == ST_SELECT && tbl_ok && r.tbl[W_FLAGS][FLAG_RATE_POS]);
	COV_LSS_TX: cover property (tx_grant && r.unconf);

endmodule : node_id_bitrate_boot_select

/* dv/setup_store_model.sv */
// setup store model: one 16-bit word per read, delay set by the bench
// assumes the selector waits for nvm_rvalid before the next read
`timescale 1ns/100ps
module setup_store_model (
	// clock and read port
	input  wire logic        core_clk,
	input  wire logic        nvm_rd,
	input  wire logic [15:0] nvm_addr,
	output logic [15:0]      nvm_rdata = 16'h0,
	output logic             nvm_rvalid = 1'b0,
	// contents and answer delay
	input  wire logic [63:0] words,
	input  wire logic [1:0]  delay
);
	logic [1:0]  cnt = 2'h0;
	logic        busy = 1'b0;
	logic [15:0] word = 16'h0;
	// ==========================================================
	// answer
	// stale data is inverted after the pulse so it never passes twice
	always @(posedge core_clk) begin
		nvm_rvalid <= 1'b0;
		if (nvm_rvalid)
			nvm_rdata <= ~nvm_rdata;
		if (nvm_rd) begin
			busy <= 1'b1;
			cnt  <= delay;
			word <= words[nvm_addr[1:0]*16 +: 16];
		end else if (busy && cnt != 2'h0)
			cnt <= cnt - 2'h1;
		else if (busy) begin
			busy       <= 1'b0;
			nvm_rvalid <= 1'b1;
			nvm_rdata  <= word;
		end
	end
endmodule : setup_store_model

/* dv/node_id_bitrate_boot_select_test.sv */
// self-checking bench for the power-on identifier and rate selector
// assumes the setup store model and the package constants
`timescale 1ns/100ps
module node_id_bitrate_boot_select_test
	import boot_select_pkg::*;
;
	logic core_clk = 1'b0, rst_n = 1'b0, nvm_rd, nvm_rvalid;
	logic [15:0] nvm_addr, nvm_rdata;
	logic canopen_mode = 1'b1, stored_id_valid = 1'b0;
	logic stored_rate_valid = 1'b0, lss_id_we = 1'b0, lss_rate_we = 1'b0;
	logic [7:0] hardware_node_select_inputs = 8'h21, stored_id = 8'h0;
	logic [7:0] lss_id = 8'h0, node_id;
	logic [1:0] stored_rate = 2'h0, lss_rate = 2'h0, bit_rate;
	logic persist_we, rx_accept, tx_grant, tx_enable, unconfigured;
	logic select_done, rx_valid = 1'b0, rx_is_lss = 1'b0;
	logic tx_req = 1'b0, tx_is_lss = 1'b0;
	logic [5:0] s_awaddr = 6'h0, s_araddr = 6'h0;
	logic [31:0] s_wdata = 32'h0, s_rdata;
	logic [3:0] s_wstrb = 4'hf;
	logic s_awvalid = 1'b0, s_wvalid = 1'b0, s_bready = 1'b0;
	logic s_arvalid = 1'b0, s_rready = 1'b0;
	logic s_awready, s_wready, s_bvalid, s_arready, s_rvalid;
	logic [1:0] s_bresp, s_rresp, delay = 2'h1;
	logic [63:0] words = 64'h0;
	int n_mismatch = 0, cmp_count = 0, cyc = 0;

	node_id_bitrate_boot_select u_dut (.*);
	setup_store_model u_store (.core_clk(core_clk), .nvm_rd(nvm_rd),
		.nvm_addr(nvm_addr), .nvm_rdata(nvm_rdata),
		.nvm_rvalid(nvm_rvalid), .words(words), .delay(delay));

	// ==========================================================
	// clock and hang guard
	always #2 core_clk = ~core_clk;
	always @(posedge core_clk) begin
		cyc++;
		if (cyc == 6000) begin
			n_mismatch++;
			stop_test();
		end
	end

	// ==========================================================
	// shared tasks
	task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("BAD %s exp %h seen %h", nm, exp, seen);
		end
	endtask : chk

	task automatic axw(logic [5:0] a, logic [31:0] d, logic [1:0] er);
		int t = 0;
		@(posedge core_clk);
		s_awaddr  <= a;
		s_wdata   <= d;
		s_awvalid <= 1'b1;
		s_wvalid  <= 1'b1;
		s_bready  <= 1'b1;
		do begin
			@(posedge core_clk);
			t++;
			if (s_awready)
				s_awvalid <= 1'b0;
			if (s_wready)
				s_wvalid <= 1'b0;
		end while (s_bvalid !== 1'b1 && t < 50);
		chk("bvalid", s_bvalid, 1);
		chk("bresp", s_bresp, er);
		s_bready <= 1'b0;
	endtask : axw

	task automatic axr(logic [5:0] a, logic [1:0] er, logic [31:0] ed);
		int t = 0;
		@(posedge core_clk);
		s_araddr  <= a;
		s_arvalid <= 1'b1;
		s_rready  <= 1'b1;
		do begin
			@(posedge core_clk);
			t++;
			if (s_arready)
				s_arvalid <= 1'b0;
		end while (s_rvalid !== 1'b1 && t < 50);
		chk("rvalid", s_rvalid, 1);
		chk("rresp", s_rresp, er);
		if (er == RESP_OKAY)
			chk("rdata", s_rdata, ed);
		s_rready <= 1'b0;
	endtask : axr

	// power-on with a given table; selection must finish before tx
	task automatic boot(logic [15:0] w0, w1, w2, w3);
		int t = 0;
		@(posedge core_clk);
		rst_n <= 1'b0;
		// short image values arrive zero-extended to 16 bits
		words <= {w3, w2, w1, w0};
		repeat (20) @(posedge core_clk);
		rst_n <= 1'b1;
		do @(negedge core_clk); while (select_done !== 1'b1 && ++t < 100);
		chk("select_done", select_done, 1);
		chk("persist_boot", persist_we, w0 == TBL_SIGNATURE);
		chk("tx_enable_early", tx_enable, 0);
		@(negedge core_clk);
		chk("tx_enable", tx_enable, 1);
	endtask : boot

	task automatic res(logic [7:0] id, logic [1:0] r, logic u);
		chk("node_id", node_id, id);
		chk("bit_rate", bit_rate, r);
		chk("unconfigured", unconfigured, u);
		axr(REG_STATUS, RESP_OKAY, {20'h0, u, 1'b1, r, id});
	endtask : res

	task automatic gate(logic lss, logic ea);
		@(posedge core_clk);
		rx_valid  <= 1'b1;
		rx_is_lss <= lss;
		tx_req    <= 1'b1;
		tx_is_lss <= lss;
		@(posedge core_clk);
		@(negedge core_clk);
		chk("rx_accept", rx_accept, ea);
		chk("tx_grant", tx_grant, ea);
		@(posedge core_clk);
		rx_valid <= 1'b0;
		tx_req   <= 1'b0;
	endtask : gate

	task automatic lss_set(logic [7:0] id, logic idw, logic [1:0] rt,
		logic rw);
		@(posedge core_clk);
		lss_id      <= id;
		lss_id_we   <= idw;
		lss_rate    <= rt;
		lss_rate_we <= rw;
		@(posedge core_clk);
		lss_id_we   <= 1'b0;
		lss_rate_we <= 1'b0;
		@(negedge core_clk);
	endtask : lss_set

	// ==========================================================
	// scenarios
	task automatic t_unconf();
		canopen_mode <= 1'b1;
		boot(TBL_SIGNATURE, 16'h3, 16'h80, 16'h4);
		res(8'hff, RATE_500K, 1);
		gate(1'b0, 1'b0);
		gate(1'b1, 1'b1);
		for (int i = 0; i < 4; i++)
			axr(REG_TBL_BASE + 6'(4 * i), RESP_OKAY,
				32'(words[i*16 +: 16]));
		axw(REG_SERIAL_ID, 32'h80, RESP_OKAY);
		chk("still_unconf", unconfigured, 1);
		axw(REG_SERIAL_ID, 32'h7f, RESP_OKAY);
		res(8'h7f, RATE_500K, 0);
		gate(1'b0, 1'b1);
		axw(6'h08, 32'h1, RESP_SLVERR);
		axr(6'h3c, RESP_SLVERR, 32'h0);
		$display("test unconf done");
	endtask : t_unconf

	task automatic t_table_rates();
		stored_id_valid <= 1'b1;
		stored_id       <= 8'h05;
		for (int r = 0; r < 4; r++) begin
			boot(TBL_SIGNATURE, 16'h2, 16'h40, 16'(r));
			res(8'h05, 2'(r), 0);
		end
		lss_set(8'h00, 1'b0, RATE_125K, 1'b1);
		chk("lss_rate", bit_rate, RATE_125K);
		lss_set(8'hff, 1'b1, RATE_125K, 1'b0);
		chk("lss_unconf", unconfigured, 1);
		chk("lss_far_id", node_id, 8'hff);
		gate(1'b0, 1'b0);
		gate(1'b1, 1'b1);
		lss_set(8'h12, 1'b1, RATE_125K, 1'b0);
		chk("lss_id", node_id, 8'h12);
		chk("lss_conf", unconfigured, 0);
		$display("test table_rates done");
	endtask : t_table_rates

	task automatic t_proprietary();
		@(posedge core_clk);
		canopen_mode      <= 1'b0;
		stored_rate_valid <= 1'b1;
		stored_rate       <= RATE_250K;
		boot(TBL_SIGNATURE, 16'h1, 16'hff, 16'h3);
		res(8'hff, RATE_250K, 0);
		hardware_node_select_inputs <= 8'h33;
		boot(TBL_SIGNATURE, 16'h1, 16'h0, 16'h3);
		res(8'h33, RATE_250K, 0);
		$display("test proprietary done");
	endtask : t_proprietary

	task automatic t_invalid();
		canopen_mode <= 1'b1;
		stored_rate  <= RATE_1M;
		boot(16'h0, 16'h3, 16'h10, 16'h0);
		res(8'h05, RATE_1M, 0);
		stored_id_valid   <= 1'b0;
		stored_rate_valid <= 1'b0;
		boot(16'h0, 16'h3, 16'h10, 16'h0);
		res(8'h33, RATE_FW_DEFAULT, 0);
		$display("test invalid done");
	endtask : t_invalid

	task automatic stop_test();
		$display("checks %0d mismatches %0d", cmp_count, n_mismatch);
		if (n_mismatch == 0 && cmp_count > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : stop_test

	initial begin
		t_unconf();
		t_table_rates();
		t_proprietary();
		t_invalid();
		stop_test();
	end
endmodule : node_id_bitrate_boot_select_test
